// [core/hf_fec_interleave_gray_chain.sv]
`timescale 1ns/1ps
`default_nettype none
// Contract
// - code up to 2400, pass uncoded at 4800
// - rate half, constraint seven convolutional code
// - two bits per input, upper first
// - coded stream runs at twice input rate
// - repeat pairs twice at 300, four at 150
// - repeat whole pairs, never split upper/lower
// - 75 uses plain rate half code
// - bitwise block matrix sized per delay setting
// - two matrices, load one while fetching other
// - forty rows, columns per rate and setting
// - load rows step nine modulo forty, columnwise
// - 75 rate uses 20x36 or 10x9, step seven
// - bypass at 4800 or zero delay setting
// - fetch next row, column minus seventeen
// - row wrap restarts at previous start plus one
// - 75 rate fetch column decrement is seven
// - group fetched bits three, two or one
// - tribit modified gray remap table
// - dibit modified gray remap table
// - single bits pass remap unchanged
// - 144 zero flush bits, pad to block end
module hf_fec_interleave_gray_chain import hf_chain_pkg::*; #(
	parameter int MAX_BITS = MATRIX_BITS
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire cfg_t cfg_in, // sampled on msg_start
	input wire logic msg_start, // one-cycle pulse, opens a message
	input wire logic flush_req, // one-cycle pulse after the end-of-message pattern
	input wire logic in_valid,
	output logic in_ready,
	input wire logic in_data,
	output logic out_valid,
	input wire logic out_ready,
	output sym_t out_sym,
	output logic flush_busy,
	output logic flush_done
);
	localparam int AW = $clog2(2 * MAX_BITS);

	// flush sequencer states, gray along the usual path
	typedef enum logic [1:0] {
		FL_IDLE = 2'b00,
		FL_CODER = 2'b01,
		FL_PAD = 2'b11,
		FL_DRAIN = 2'b10
	} fl_t;

	cfg_t cfg; // active message configuration
	fl_t fl; // flush phase
	logic [7:0] fl_cnt; // coder flush bits fed so far
	logic [5:0] sr; // coder memory, bit 5 newest
	logic pu; // upper coded bit held
	logic pl; // lower coded bit held
	logic have; // a coded pair is pending
	logic phase; // 0 upper next, 1 lower next
	logic [1:0] rep_left; // remaining extra repeats of the pair
	logic [1:0] full; // per matrix: block loaded, waiting for fetch
	logic ld_bank; // matrix being loaded
	logic fe_bank; // matrix being fetched
	logic [5:0] ld_row;
	logic [5:0] ld_n; // bits already placed in current column
	logic [9:0] ld_col;
	logic [5:0] fe_row;
	logic [9:0] fe_col;
	logic [9:0] fe_base; // column used at the last row-zero fetch
	logic mem [0:2*MAX_BITS-1]; // both interleave matrices
	logic [2:0] gsh; // partial symbol, first bit shifted highest
	logic [1:0] gcnt; // bits gathered so far

	// geometry by rate and setting
	wire is75 = (cfg.rate == R75);
	wire uncoded = (cfg.rate == R4800);
	wire ilv_on = !uncoded && (cfg.ilv != ILV_ZERO);
	wire [5:0] rows = is75 ? ((cfg.ilv == ILV_LONG) ? ROWS_75_LONG : ROWS_75_SHORT)
		: ROWS_STD;
	wire [5:0] ld_step = is75 ? LOAD_STEP_75 : LOAD_STEP_STD;
	wire [9:0] fe_dec = is75 ? FETCH_DEC_75 : FETCH_DEC_STD;
	logic [9:0] cols;
	always_comb begin
		// column count for the selected block
		unique case (cfg.rate)
			R2400: cols = (cfg.ilv == ILV_LONG) ? COLS_2400_LONG : COLS_2400_SHORT;
			R1200: cols = (cfg.ilv == ILV_LONG) ? COLS_1200_LONG : COLS_1200_SHORT;
			R75: cols = (cfg.ilv == ILV_LONG) ? COLS_75_LONG : COLS_75_SHORT;
			default: cols = (cfg.ilv == ILV_LONG) ? COLS_600_LONG : COLS_600_SHORT;
		endcase
	end
	// pair repeats beyond the first: one at 300, three at 150
	wire [1:0] reps = (cfg.rate == R150) ? 2'h3 : ((cfg.rate == R300) ? 2'h1 : 2'h0);
	// bits per channel symbol
	wire [1:0] nbits = (uncoded || cfg.rate == R2400) ? 2'h3
		: ((cfg.rate == R1200 || is75) ? 2'h2 : 2'h1);

	// bit source: data from upstream or self-made zeros while flushing
	wire ld_at_start = (ld_col == 10'h000) && (ld_n == 6'h00);
	wire fl_feed = (fl == FL_CODER) || ((fl == FL_PAD) && !ld_at_start);
	wire feed_valid = fl_feed || ((fl == FL_IDLE) && in_valid);
	wire feed_bit = fl_feed ? 1'b0 : in_data;

	// coded stream toward interleaver or bypass
	logic cb_ready;
	wire cb_valid = uncoded ? feed_valid : have;
	wire cb_data = uncoded ? feed_bit : (phase ? pl : pu);
	wire take = !uncoded && feed_valid && !have;
	wire feed_take = uncoded ? (feed_valid && cb_ready) : take;
	assign in_ready = (fl == FL_IDLE) && (uncoded ? cb_ready : !have);
	wire [6:0] tapv = {feed_bit, sr};

	// coder: encode one input, then emit pair bits, repeating whole pairs
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sr <= 6'h00;
			pu <= 1'b0;
			pl <= 1'b0;
			have <= 1'b0;
			phase <= 1'b0;
			rep_left <= 2'h0;
		end else if (msg_start) begin
			sr <= 6'h00;
			have <= 1'b0;
			phase <= 1'b0;
		end else if (take) begin
			pu <= ^(tapv & TAPS_UPPER);
			pl <= ^(tapv & TAPS_LOWER);
			sr <= {feed_bit, sr[5:1]};
			have <= 1'b1;
			phase <= 1'b0;
			rep_left <= reps;
		end else if (have && cb_ready) begin
			phase <= !phase;
			if (phase) begin
				// a pair is only repeated once both halves went out
				if (rep_left == 2'h0) begin
					have <= 1'b0;
				end else begin
					rep_left <= rep_left - 2'h1;
				end
			end
		end
	end

	// flush sequencing: coder flush, block padding, then wait for emptiness
	wire drained = (full == 2'b00) && !have && (gcnt == 2'h0) && !out_valid;
	assign flush_busy = (fl != FL_IDLE);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fl <= FL_IDLE;
			fl_cnt <= 8'h00;
			flush_done <= 1'b0;
		end else begin
			flush_done <= 1'b0;
			unique case (fl)
				FL_IDLE: begin
					if (flush_req) begin
						fl <= FL_CODER;
						fl_cnt <= 8'h00;
					end
				end
				FL_CODER: begin
					if (feed_take) begin
						fl_cnt <= fl_cnt + 8'h01;
						// bypassed matrix: coder flush bits only
						if (fl_cnt == FLUSH_BITS - 8'h01) begin
							fl <= ilv_on ? FL_PAD : FL_DRAIN;
						end
					end
				end
				FL_PAD: begin
					// pad until the block with the last flush bit is closed
					if (!have && ld_at_start) begin
						fl <= FL_DRAIN;
					end
				end
				FL_DRAIN: begin
					if (drained) begin
						fl <= FL_IDLE;
						flush_done <= 1'b1;
					end
				end
			endcase
		end
	end

	// interleaver load addressing
	wire ld_ok = !full[ld_bank];
	wire ld_we = ilv_on && cb_valid && ld_ok;
	wire ld_last_in_col = (ld_n == rows - 6'h01);
	wire ld_last = ld_last_in_col && (ld_col == cols - 10'h001);
	wire [6:0] ld_sum = {1'b0, ld_row} + {1'b0, ld_step};
	wire [5:0] ld_row_nx = (ld_sum >= {1'b0, rows}) ? 6'(ld_sum - {1'b0, rows}) : ld_sum[5:0];
	wire [AW-1:0] ld_addr = AW'(ld_bank ? MAX_BITS : 0) + AW'(ld_row) * AW'(cols) + AW'(ld_col);

	// fetch addressing
	wire fe_valid = ilv_on && full[fe_bank];
	wire fe_last_row = (fe_row == rows - 6'h01);
	wire fe_last = fe_last_row && (fe_base == cols - 10'h001);
	wire [9:0] fe_col_nx = (fe_col >= fe_dec) ? (fe_col - fe_dec) : (fe_col + cols - fe_dec);
	wire [AW-1:0] fe_addr = AW'(fe_bank ? MAX_BITS : 0) + AW'(fe_row) * AW'(cols) + AW'(fe_col);
	wire fe_data = mem[fe_addr];

	// gather input: fetched bits or bypassed coded bits
	wire gb_ready = !out_valid;
	wire gb_valid = ilv_on ? fe_valid : cb_valid;
	wire gb_data = ilv_on ? fe_data : cb_data;
	assign cb_ready = ilv_on ? ld_ok : gb_ready;
	wire fe_take = ilv_on && fe_valid && gb_ready;

	// matrix storage, no reset on the array
	always_ff @(posedge clk) begin
		if (ld_we) begin
			mem[ld_addr] <= cb_data;
		end
	end

	// load position: column by column, row stepping modulo the row count
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ld_row <= 6'h00;
			ld_n <= 6'h00;
			ld_col <= 10'h000;
			ld_bank <= 1'b0;
		end else if (msg_start) begin
			ld_row <= 6'h00;
			ld_n <= 6'h00;
			ld_col <= 10'h000;
			ld_bank <= 1'b0;
		end else if (ld_we) begin
			if (ld_last_in_col) begin
				ld_row <= 6'h00;
				ld_n <= 6'h00;
				ld_col <= ld_last ? 10'h000 : ld_col + 10'h001;
				if (ld_last) begin
					ld_bank <= !ld_bank;
				end
			end else begin
				ld_row <= ld_row_nx;
				ld_n <= ld_n + 6'h01;
			end
		end
	end

	// full flags: set on the last load write, cleared on the last fetch
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			full <= 2'b00;
		end else if (msg_start) begin
			full <= 2'b00;
		end else begin
			// banks differ whenever both events coincide, so no conflict
			if (fe_take && fe_last) begin
				full[fe_bank] <= 1'b0;
			end
			if (ld_we && ld_last) begin
				full[ld_bank] <= 1'b1;
			end
		end
	end

	// fetch position: diagonal walk with column restart per row wrap
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fe_row <= 6'h00;
			fe_col <= 10'h000;
			fe_base <= 10'h000;
			fe_bank <= 1'b0;
		end else if (msg_start) begin
			fe_row <= 6'h00;
			fe_col <= 10'h000;
			fe_base <= 10'h000;
			fe_bank <= 1'b0;
		end else if (fe_take) begin
			if (fe_last) begin
				fe_row <= 6'h00;
				fe_col <= 10'h000;
				fe_base <= 10'h000;
				fe_bank <= !fe_bank;
			end else if (fe_last_row) begin
				fe_row <= 6'h00;
				fe_col <= fe_base + 10'h001;
				fe_base <= fe_base + 10'h001;
			end else begin
				fe_row <= fe_row + 6'h01;
				fe_col <= fe_col_nx;
			end
		end
	end

	// modified gray remap of a gathered symbol
	wire [2:0] g_next = {gsh[1:0], gb_data};
	logic [2:0] remap;
	always_comb begin
		unique case (nbits)
			2'h3: remap = {g_next[2], g_next[2] ^ g_next[1], ^g_next};
			2'h2: remap = {1'b0, g_next[1], g_next[1] ^ g_next[0]};
			default: remap = {2'b00, g_next[0]};
		endcase
	end

	// symbol gathering and output register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			gsh <= 3'h0;
			gcnt <= 2'h0;
			out_valid <= 1'b0;
			out_sym <= '0;
		end else if (msg_start) begin
			gcnt <= 2'h0;
			out_valid <= 1'b0;
		end else begin
			if (out_valid && out_ready) begin
				out_valid <= 1'b0;
			end
			if (gb_valid && gb_ready) begin
				if (gcnt + 2'h1 == nbits) begin
					out_sym <= '{bits: remap, width: nbits};
					out_valid <= 1'b1;
					gcnt <= 2'h0;
				end else begin
					gsh <= g_next;
					gcnt <= gcnt + 2'h1;
				end
			end
		end
	end

	// latch configuration for the whole message
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg <= '{rate: R2400, ilv: ILV_SHORT};
		end else if (msg_start) begin
			cfg <= cfg_in;
		end
	end
endmodule
`default_nettype wire

// [pkg/hf_chain_pkg.sv]
package hf_chain_pkg;
	// throughput rates of the transmit chain
	typedef enum logic [2:0] {
		R75 = 3'h0,
		R150 = 3'h1,
		R300 = 3'h2,
		R600 = 3'h3,
		R1200 = 3'h4,
		R2400 = 3'h5,
		R4800 = 3'h6
	} rate_t;
	// interleave delay setting
	typedef enum logic [1:0] {
		ILV_ZERO = 2'h0,
		ILV_SHORT = 2'h1,
		ILV_LONG = 2'h2
	} ilv_t;
	// message configuration, latched at message start
	typedef struct packed {
		rate_t rate;
		ilv_t ilv;
	} cfg_t;
	// channel symbol handed downstream
	typedef struct packed {
		logic [2:0] bits; // remapped value, lsb-aligned
		logic [1:0] width; // 1, 2 or 3 bits valid
	} sym_t;
	// coder constants: taps over {current bit, six stored bits newest first}
	localparam logic [6:0] TAPS_UPPER = 7'h5b;
	localparam logic [6:0] TAPS_LOWER = 7'h79;
	localparam logic [7:0] FLUSH_BITS = 8'h90;
	// interleaver geometry
	localparam logic [5:0] ROWS_STD = 6'h28;
	localparam logic [5:0] ROWS_75_LONG = 6'h14;
	localparam logic [5:0] ROWS_75_SHORT = 6'h0a;
	localparam logic [5:0] LOAD_STEP_STD = 6'h09;
	localparam logic [5:0] LOAD_STEP_75 = 6'h07;
	localparam logic [9:0] FETCH_DEC_STD = 10'h011;
	localparam logic [9:0] FETCH_DEC_75 = 10'h007;
	localparam logic [9:0] COLS_2400_LONG = 10'h240;
	localparam logic [9:0] COLS_1200_LONG = 10'h120;
	localparam logic [9:0] COLS_600_LONG = 10'h090;
	localparam logic [9:0] COLS_75_LONG = 10'h024;
	localparam logic [9:0] COLS_2400_SHORT = 10'h048;
	localparam logic [9:0] COLS_1200_SHORT = 10'h024;
	localparam logic [9:0] COLS_600_SHORT = 10'h012;
	localparam logic [9:0] COLS_75_SHORT = 10'h009;
	localparam int MATRIX_BITS = 23040;
endpackage

// [testbench/hf_chain_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module hf_chain_asserts import hf_chain_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire cfg_t cfg_in,
	input wire logic msg_start,
	input wire logic flush_req,
	input wire logic in_valid,
	input wire logic in_ready,
	input wire logic in_data,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire sym_t out_sym,
	input wire logic flush_busy,
	input wire logic flush_done
);
	rate_t rate; // rate latched for the current message
	int fcnt; // cycles since the last flush request
	wire take = in_valid && in_ready;
	wire [1:0] wexp = (rate == R4800 || rate == R2400) ? 2'h3 :
		(rate == R1200 || rate == R75) ? 2'h2 : 2'h1;
	// mirror the config latch; reset default matches the design's
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rate <= R2400;
			fcnt <= 0;
		end else begin
			if (msg_start) rate <= cfg_in.rate;
			fcnt <= flush_req ? 0 : fcnt + 1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_hold;
		out_valid && !out_ready && !msg_start |=> out_valid && $stable(out_sym);
	endproperty
	a_hold: assert property (p_hold) else $error("symbol changed before accept");
	property p_width;
		out_valid |-> out_sym.width == wexp;
	endproperty
	a_width: assert property (p_width) else $error("symbol width wrong for rate");
	property p_lsb;
		out_valid && out_sym.width == 2'h1 |-> out_sym.bits[2:1] == 2'h0;
	endproperty
	a_lsb: assert property (p_lsb) else $error("single bit symbol not lsb aligned");
	property p_pair;
		rate != R4800 && take && !msg_start |=> !in_ready;
	endproperty
	a_pair: assert property (p_pair) else $error("coder took a bit while pair pending");
	property p_rep2;
		rate == R300 && take && !msg_start |=> !in_ready [*4];
	endproperty
	a_rep2: assert property (p_rep2) else $error("pair not sent twice");
	property p_rep4;
		rate == R150 && take && !msg_start |=> !in_ready [*8];
	endproperty
	a_rep4: assert property (p_rep4) else $error("pair not sent four times");
	property p_lock;
		flush_busy |-> !in_ready;
	endproperty
	a_lock: assert property (p_lock) else $error("input open while flushing");
	property p_flush_on;
		flush_req && !flush_busy |=> flush_busy;
	endproperty
	a_flush_on: assert property (p_flush_on) else $error("flush did not start");
	property p_done;
		flush_done |-> !flush_busy && !out_valid && fcnt >= 144 ##1 !flush_done;
	endproperty
	a_done: assert property (p_done) else $error("flush ended early or badly");
	property p_start;
		msg_start |=> !out_valid;
	endproperty
	a_start: assert property (p_start) else $error("message start left a symbol");
	c_tri: cover property (out_valid && out_ready && out_sym.width == 2'h3);
	c_rep4: cover property (rate == R150 && take);
	c_done: cover property (flush_done);
endmodule
bind hf_fec_interleave_gray_chain hf_chain_asserts chk (.clk, .sys_rst, .cfg_in,
	.msg_start, .flush_req, .in_valid, .in_ready, .in_data, .out_valid, .out_ready,
	.out_sym, .flush_busy, .flush_done);
`default_nettype wire

// [testbench/hf_sym_sink.sv]
`timescale 1ns/1ps
`default_nettype none
module hf_sym_sink import hf_chain_pkg::*; (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic slow,
	input wire logic out_valid,
	input wire sym_t out_sym,
	output logic out_ready
);
	sym_t got[$]; // accepted symbols, oldest first
	logic [1:0] ph; // stall phase
	// slow mode is ready one cycle in four, blind to valid
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_ready <= 1'b0;
			ph <= 2'h0;
		end else begin
			ph <= ph + 2'h1;
			out_ready <= !slow || ph == 2'h2;
			if (out_valid && out_ready) got.push_back(out_sym);
		end
	end
endmodule
`default_nettype wire

// [testbench/tb_hf_fec_interleave_gray_chain.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_hf_fec_interleave_gray_chain import hf_chain_pkg::*; ;
	typedef struct {
		rate_t rate;
		ilv_t ilv;
		int n, rows, cols, step, dec, w, rep;
		logic [23:0] pat;
	} row_t;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	cfg_t cfg_in = '0;
	logic msg_start = 1'b0, flush_req = 1'b0, in_valid = 1'b0, in_data = 1'b0, slow = 1'b0;
	logic in_ready, out_valid, out_ready, flush_busy, flush_done;
	sym_t out_sym;
	int err_count = 0, compares = 0;
	sym_t exp_q[$]; // symbols the current row should give
	// rows of rate, delay, bit count, geometry, symbol width, repeats, bits
	// interleaved rows also reach the long setting and the 2400 and 1200 geometries
	row_t tbl[11] = '{
		'{R4800, ILV_ZERO, 24, 0, 0, 0, 0, 3, 1, 24'h053977},
		'{R2400, ILV_ZERO, 6, 0, 0, 0, 0, 3, 1, 24'h00002d},
		'{R1200, ILV_ZERO, 8, 0, 0, 0, 0, 2, 1, 24'h0000b5},
		'{R600, ILV_ZERO, 8, 0, 0, 0, 0, 1, 1, 24'h000096},
		'{R300, ILV_ZERO, 4, 0, 0, 0, 0, 1, 2, 24'h00000d},
		'{R150, ILV_ZERO, 3, 0, 0, 0, 0, 1, 4, 24'h000005},
		'{R75, ILV_SHORT, 9, 10, 9, 7, 7, 2, 1, 24'h0001a5},
		'{R600, ILV_SHORT, 8, 40, 18, 9, 17, 1, 1, 24'h00003c},
		'{R2400, ILV_SHORT, 6, 40, 72, 9, 17, 3, 1, 24'h00002d},
		'{R75, ILV_LONG, 9, 20, 36, 7, 7, 2, 1, 24'h0001a5},
		'{R1200, ILV_SHORT, 8, 40, 36, 9, 17, 2, 1, 24'h0000b5}
	};
	always #2 clk = ~clk;
	hf_fec_interleave_gray_chain DUT (.clk, .sys_rst, .cfg_in, .msg_start, .flush_req,
		.in_valid, .in_ready, .in_data, .out_valid, .out_ready, .out_sym, .flush_busy,
		.flush_done);
	hf_sym_sink sink (.clk, .sys_rst, .slow, .out_valid, .out_sym, .out_ready);
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want) begin
			err_count++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic give_verdict;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// reference chain: coder with flush zeros, repeat, block interleave, remap
	task automatic model(input row_t r);
		logic s[$];
		logic t[$];
		logic m[];
		logic [5:0] sr;
		logic [6:0] v;
		logic [2:0] b;
		int n, c;
		sr = '0;
		exp_q.delete();
		for (int i = 0; i < r.n + 144; i++) begin
			v = {i < r.n ? r.pat[r.n - 1 - i] : 1'b0, sr};
			sr = v[6:1];
			if (r.rate == R4800) s.push_back(v[6]);
			else repeat (r.rep) begin
				s.push_back(^(v & TAPS_UPPER));
				s.push_back(^(v & TAPS_LOWER));
			end
		end
		n = r.rows * r.cols;
		if (n == 0) t = s;
		else begin
			while (s.size() % n != 0) s.push_back(1'b0);
			m = new[n];
			for (int k = 0; k < s.size(); k++) begin
				m[k % n / r.rows * r.rows + k % r.rows * r.step % r.rows] = s[k];
				if (k % n == n - 1) begin
					for (int j = 0; j < n; j++) begin
						c = ((j / r.rows - r.dec * (j % r.rows)) % r.cols + r.cols) % r.cols;
						t.push_back(m[c * r.rows + j % r.rows]);
					end
				end
			end
		end
		for (int i = 0; i + r.w <= t.size(); i += r.w) begin
			b = '0;
			for (int j = 0; j < r.w; j++) b = {b[1:0], t[i + j]};
			if (r.w == 3) b = {b[2], b[2] ^ b[1], b[2] ^ b[1] ^ b[0]};
			if (r.w == 2) b = {1'b0, b[1], b[1] ^ b[0]};
			exp_q.push_back(sym_t'{b, 2'(r.w)});
		end
	endtask
	// offer one bit, hold it until taken
	task automatic send_bit(input logic b);
		in_data <= b;
		in_valid <= 1'b1;
		@(negedge clk);
		while (in_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
	endtask
	// open a message; clear captures once stale symbols can no longer land
	task automatic pulse_start(input row_t r);
		cfg_in <= '{r.rate, r.ilv};
		msg_start <= 1'b1;
		@(posedge clk);
		msg_start <= 1'b0;
		@(posedge clk);
		sink.got.delete();
	endtask
	task automatic run_row(input row_t r);
		model(r);
		pulse_start(r);
		for (int i = r.n - 1; i >= 0; i--) send_bit(r.pat[i]);
		in_valid <= 1'b0;
		flush_req <= 1'b1;
		@(posedge clk);
		flush_req <= 1'b0;
		@(negedge clk);
		while (flush_done !== 1'b1) @(negedge clk);
		chk(sink.got.size(), exp_q.size());
		foreach (exp_q[i]) chk(sink.got[i], exp_q[i]);
		@(posedge clk);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		chk({in_ready, out_valid, out_sym, flush_busy, flush_done}, 32'h00000100);
		sys_rst <= 1'b0;
		@(posedge clk);
		foreach (tbl[i]) begin
			slow <= i[0];
			run_row(tbl[i]);
		end
		// abandoned message: coder memory must not leak into the next one
		pulse_start(tbl[2]);
		repeat (5) send_bit(1'b1);
		in_valid <= 1'b0;
		run_row(tbl[2]);
		// reset in mid message, then a clean run
		pulse_start(tbl[0]);
		repeat (4) send_bit(1'b1);
		sys_rst <= 1'b1;
		in_valid <= 1'b0;
		@(posedge clk);
		chk({out_valid, flush_busy}, 32'h0);
		sys_rst <= 1'b0;
		run_row(tbl[0]);
		give_verdict();
	end
	// hang guard, well beyond the expected run
	initial begin
		#300000;
		err_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
